// ==== qfr_pkg.sv ====
// Shared constants, types and helpers for the quad read link
package qfr_pkg;
  localparam int QFR_ADDR_W = 24;
  localparam int QFR_WRAP_W = 3;
  localparam int QFR_APB_AW = 8;
  localparam int QFR_SCK_HALF = 8;

  localparam logic [7:0] QFR_OP_FAST = 8'heb;
  localparam logic [7:0] QFR_OP_WORD = 8'he7;
  localparam logic [7:0] QFR_OP_OCT = 8'he3;
  localparam logic [7:0] QFR_OP_RST = 8'hff;

  localparam logic [2:0] QFR_DUMMY_FAST = 3'h4;
  localparam logic [2:0] QFR_DUMMY_WORD = 3'h2;
  localparam logic [2:0] QFR_DUMMY_OCT = 3'h0;
  localparam logic [2:0] QFR_OPC_LAST = 3'h7;
  localparam logic [2:0] QFR_ADDR_LAST = 3'h5;
  localparam logic [2:0] QFR_MODE_LAST = 3'h1;

  localparam logic [1:0] QFR_CONT_CODE = 2'h2;
  localparam logic [7:0] QFR_MODE_KEEP = 8'h20;
  localparam logic [7:0] QFR_MODE_EXIT = 8'h00;
  localparam logic [2:0] QFR_WRAP_RST = 3'h1;
  localparam int QFR_WRAP_DIS_BIT = 0;
  localparam logic [23:0] QFR_ALIGN_WORD = 24'hfffffe;
  localparam logic [23:0] QFR_ALIGN_OCT = 24'hfffff0;

  localparam logic [7:0] QFR_REG_CTRL = 8'h00;
  localparam logic [7:0] QFR_REG_ADDR = 8'h04;
  localparam logic [7:0] QFR_REG_STAT = 8'h08;
  localparam logic [7:0] QFR_REG_RDATA = 8'h0c;
  localparam int QFR_CTRL_KEEP_BIT = 2;
  localparam int QFR_CTRL_LEN_LSB = 3;

  typedef enum logic [1:0] {
    QFR_CMD_FAST = 2'b00,
    QFR_CMD_WORD = 2'b01,
    QFR_CMD_OCT = 2'b10,
    QFR_CMD_RST = 2'b11
  } qfr_cmd_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_OPC = 3'b001, D_ADDR = 3'b010, D_MODE = 3'b011,
    D_DUMMY = 3'b100, D_DATA = 3'b101, D_IGNORE = 3'b110
  } qfr_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_OPC = 3'b001, H_ADDR = 3'b010, H_MODE = 3'b011,
    H_DUMMY = 3'b100, H_DATA = 3'b101, H_END = 3'b110, H_GAP = 3'b111
  } qfr_hst_t;

  function automatic logic [7:0] qfr_opcode(qfr_cmd_t c);
    case (c)
      QFR_CMD_FAST: qfr_opcode = QFR_OP_FAST;
      QFR_CMD_WORD: qfr_opcode = QFR_OP_WORD;
      QFR_CMD_OCT: qfr_opcode = QFR_OP_OCT;
      default: qfr_opcode = QFR_OP_RST;
    endcase
  endfunction : qfr_opcode

  function automatic logic [2:0] qfr_dummy(qfr_cmd_t c);
    case (c)
      QFR_CMD_FAST: qfr_dummy = QFR_DUMMY_FAST;
      QFR_CMD_WORD: qfr_dummy = QFR_DUMMY_WORD;
      default: qfr_dummy = QFR_DUMMY_OCT;
    endcase
  endfunction : qfr_dummy
endpackage : qfr_pkg

// ==== qfr_link_if.sv ====
// Quad link wires between host controller and flash read engine
`timescale 1ns/1ps
interface qfr_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] h_io_out;
  logic h_io_oe;
  logic [3:0] d_io_out;
  logic d_io_oe;
  logic [3:0] io;

  // Pull-ups keep released lines high
  assign io = h_io_oe ? h_io_out : (d_io_oe ? d_io_out : 4'hf);

  modport host (output cs_n, sck, h_io_out, h_io_oe, input io);
  modport dev (input cs_n, sck, io, output d_io_out, d_io_oe);
endinterface : qfr_link_if

// ==== qfr_sync.sv ====
// Two-stage synchroniser for link inputs
`timescale 1ns/1ps
module qfr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic i_ce,
  input logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  import qfr_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qfr_sync_st_t;

  qfr_sync_st_t r;
  qfr_sync_st_t n;

  always_comb begin
    n.s1 = i_d;
    n.s2 = r.s1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= {RST_VAL, RST_VAL};
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_q = r.s2;
endmodule : qfr_sync

// ==== qfr_dev_end.sv ====
// Flash side quad read engine: command decode, continuous mode, wrap
`timescale 1ns/1ps

// Overview of operation
// - EBh quad address/data, four dummy clocks
// - EBh accepted only with quad enable set
// - Mode byte follows address; low nibble ignored
// - Mode bits 10 after EBh skip next opcode
// - Other mode bits demand full opcode next
// - Continuous mode takes address on first clocks
// - Host releases lines before first data fall
// - Mode reset clears stored continuous mode
// - Wrap setting applies to following EBh reads
// - Wrap confines data to 8-64 byte section
// - Wrap starts at address, loops to section start
// - Three wrap bits: disable plus length field
// - E7h word aligned, two dummy clocks
// - E7h accepted only with quad enable set
// - E7h mode bits 10 skip next opcode
// - Wrap setting applies equally to E7h
// - E3h sixteen-byte aligned, no dummy clocks
// - E3h accepted only with quad enable set
// - E3h mode bits 10 skip next opcode
// - Length codes 8..64; disable bit resets high
// - Host exits continuous mode with all ones
module qfr_dev_end (
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic i_ce,
  qfr_link_if.dev link,
  input logic i_quad_io_enable,
  input logic i_wrap_wr,
  input logic [qfr_pkg::QFR_WRAP_W-1:0] i_wrap_bits,
  input logic [7:0] i_mem_data,
  output logic [qfr_pkg::QFR_ADDR_W-1:0] o_mem_addr,
  output logic o_cont_mode,
  output logic o_active
);
  import qfr_pkg::*;

  typedef struct packed {
    qfr_dst_t st;
    logic [2:0] cnt;
    logic [7:0] op;
    qfr_cmd_t cmd;
    logic cont;
    logic [QFR_ADDR_W-1:0] addr;
    logic [7:0] mode;
    logic nib_lo;
    logic [3:0] hold;
    logic [3:0] out;
    logic oe;
    logic [QFR_WRAP_W-1:0] wrap;
    logic sck_d;
    logic cs_d;
  } qfr_dev_st_t;

  qfr_dev_st_t r;
  qfr_dev_st_t n;
  logic [5:0] syn;
  logic cs_s;
  logic sck_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;

  // Wrap only touches the low address byte, so a burst stays in its page unless wrap is disabled
  function automatic logic [QFR_ADDR_W-1:0] next_addr(
    logic [QFR_ADDR_W-1:0] a,
    logic [QFR_WRAP_W-1:0] w
  );
    logic [7:0] m;
    logic [7:0] lo;
    m = 8'(8'h08 << w[2:1]) - 8'h01;
    lo = a[7:0] + 8'h01;
    if (w[QFR_WRAP_DIS_BIT]) begin
      next_addr = a + 24'h000001;
    end else begin
      next_addr = {a[23:8], (a[7:0] & ~m) | (lo & m)};
    end
  endfunction : next_addr

  qfr_sync #(
    .W(6),
    .RST_VAL(6'h20)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_d({link.cs_n, link.sck, link.io}),
    .o_q(syn)
  );

  assign cs_s = syn[5];
  assign sck_s = syn[4];
  assign io_s = syn[3:0];
  assign rise = sck_s & ~r.sck_d;
  assign fall = ~sck_s & r.sck_d;

  always_comb begin
    n = r;
    n.sck_d = sck_s;
    n.cs_d = cs_s;
    if (i_wrap_wr) begin
      n.wrap = i_wrap_bits;
    end
    if (cs_s) begin
      n.st = D_IDLE;
      n.oe = 1'b0;
    end else if (r.cs_d) begin
      n.cnt = 3'h0;
      n.st = r.cont ? D_ADDR : D_OPC;
    end else if (rise) begin
      case (r.st)
        D_OPC: begin
          n.op = {r.op[6:0], io_s[0]};
          n.cnt = r.cnt + 3'h1;
          if (r.cnt == QFR_OPC_LAST) begin
            n.cnt = 3'h0;
            n.st = D_IGNORE;
            if (n.op == QFR_OP_RST) begin
              n.cont = 1'b0;
            end
            if (i_quad_io_enable) begin
              case (n.op)
                QFR_OP_FAST: begin
                  n.cmd = QFR_CMD_FAST;
                  n.st = D_ADDR;
                end
                QFR_OP_WORD: begin
                  n.cmd = QFR_CMD_WORD;
                  n.st = D_ADDR;
                end
                QFR_OP_OCT: begin
                  n.cmd = QFR_CMD_OCT;
                  n.st = D_ADDR;
                end
                default: begin
                  n.st = D_IGNORE;
                end
              endcase
            end
          end
        end
        D_ADDR: begin
          n.addr = {r.addr[19:0], io_s};
          n.cnt = r.cnt + 3'h1;
          if (r.cnt == QFR_ADDR_LAST) begin
            n.cnt = 3'h0;
            n.st = D_MODE;
          end
        end
        D_MODE: begin
          n.mode = {r.mode[3:0], io_s};
          n.cnt = r.cnt + 3'h1;
          if (r.cnt == QFR_MODE_LAST) begin
            // Only bits 5:4 matter; an all-ones byte always ends the mode
            n.cont = (n.mode[5:4] == QFR_CONT_CODE);
            if (r.cmd == QFR_CMD_WORD) begin
              n.addr = r.addr & QFR_ALIGN_WORD;
            end
            if (r.cmd == QFR_CMD_OCT) begin
              n.addr = r.addr & QFR_ALIGN_OCT;
            end
            n.cnt = 3'h0;
            n.nib_lo = 1'b0;
            if (qfr_dummy(r.cmd) == 3'h0) begin
              n.st = D_DATA;
            end else begin
              n.st = D_DUMMY;
            end
          end
        end
        D_DUMMY: begin
          n.cnt = r.cnt + 3'h1;
          if (r.cnt == qfr_dummy(r.cmd) - 3'h1) begin
            n.cnt = 3'h0;
            n.st = D_DATA;
          end
        end
        default: begin
          n.cnt = r.cnt;
        end
      endcase
    end else if (fall && r.st == D_DATA) begin
      // Lines turn to output only here, after the host let go
      n.oe = 1'b1;
      n.nib_lo = ~r.nib_lo;
      if (!r.nib_lo) begin
        n.out = i_mem_data[7:4];
        n.hold = i_mem_data[3:0];
      end else begin
        n.out = r.hold;
        n.addr = next_addr(r.addr, r.wrap);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.cs_d <= 1'b1;
      r.wrap <= QFR_WRAP_RST;
    end else if (i_ce) begin
      r <= n;
    end
  end

  // Memory read is combinational on the same clock
  assign o_mem_addr = r.addr;
  assign o_cont_mode = r.cont;
  assign o_active = (r.st != D_IDLE);
  assign link.d_io_out = r.out;
  assign link.d_io_oe = r.oe;
endmodule : qfr_dev_end

// ==== qfr_host_end.sv ====
// Host controller end: APB registers driving quad read frames
`timescale 1ns/1ps
module qfr_host_end #(
  parameter int SCK_HALF = qfr_pkg::QFR_SCK_HALF
) (
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic i_ce,
  qfr_link_if.host link,
  input logic i_psel,
  input logic i_penable,
  input logic i_pwrite,
  input logic [qfr_pkg::QFR_APB_AW-1:0] i_paddr,
  input logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import qfr_pkg::*;

  typedef struct packed {
    qfr_hst_t st;
    logic [7:0] div;
    logic sck;
    logic cs_n;
    logic [2:0] cnt;
    logic [3:0] out;
    logic oe;
    qfr_cmd_t cmd;
    logic keep;
    logic [1:0] len;
    logic [QFR_ADDR_W-1:0] addr;
    logic cont;
    logic done;
    logic [31:0] rdata;
    logic [31:0] prdata;
    logic slverr;
  } qfr_host_st_t;

  qfr_host_st_t r;
  qfr_host_st_t n;
  logic [3:0] io_s;
  logic setup;
  logic acc;
  logic mapped;

  // Returns {oe, nibble} for the given phase position
  function automatic logic [4:0] hnib(qfr_hst_t st, logic [2:0] c,
                                     qfr_cmd_t cmd, logic [23:0] a,
                                     logic keep);
    logic [23:0] sh;
    logic [7:0] op;
    logic [7:0] m;
    sh = a << {c, 2'b00};
    op = qfr_opcode(cmd);
    m = keep ? QFR_MODE_KEEP : QFR_MODE_EXIT;
    case (st)
      H_OPC: hnib = {4'hf, op[3'h7 - c]};
      H_ADDR: hnib = {1'b1, sh[23:20]};
      H_MODE: hnib = {1'b1, c[0] ? m[3:0] : m[7:4]};
      default: hnib = 5'h00;
    endcase
  endfunction : hnib

  qfr_sync #(
    .W(4),
    .RST_VAL(4'hf)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_d(link.io),
    .o_q(io_s)
  );

  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable;
  assign mapped = (i_paddr == QFR_REG_CTRL) || (i_paddr == QFR_REG_ADDR) ||
                  (i_paddr == QFR_REG_STAT) || (i_paddr == QFR_REG_RDATA);

  always_comb begin
    n = r;
    if (setup) begin
      n.slverr = ~mapped;
      case (i_paddr)
        QFR_REG_CTRL: n.prdata = {27'h0, r.len, r.keep, r.cmd};
        QFR_REG_ADDR: n.prdata = {8'h00, r.addr};
        QFR_REG_STAT: n.prdata = {29'h0, r.done, r.cont, r.st != H_IDLE};
        QFR_REG_RDATA: n.prdata = r.rdata;
        default: n.prdata = 32'h0;
      endcase
    end
    if (r.st == H_IDLE) begin
      if (acc && i_pwrite && i_paddr == QFR_REG_ADDR) begin
        n.addr = i_pwdata[23:0];
      end
      if (acc && i_pwrite && i_paddr == QFR_REG_CTRL) begin
        n.cmd = qfr_cmd_t'(i_pwdata[1:0]);
        n.keep = i_pwdata[QFR_CTRL_KEEP_BIT];
        n.len = i_pwdata[QFR_CTRL_LEN_LSB +: 2];
        n.done = 1'b0;
        n.cs_n = 1'b0;
        n.sck = 1'b0;
        n.div = 8'h00;
        n.cnt = 3'h0;
        n.rdata = 32'h0;
        if (r.cont && n.cmd != QFR_CMD_RST) begin
          n.st = H_ADDR;
        end else begin
          n.st = H_OPC;
        end
        {n.oe, n.out} = hnib(n.st, 3'h0, n.cmd, r.addr, n.keep);
      end
    end else if (r.st == H_GAP) begin
      n.div = r.div + 8'h01;
      if (r.div == 8'(SCK_HALF - 1)) begin
        n.st = H_IDLE;
        n.done = 1'b1;
      end
    end else if (r.div == 8'(SCK_HALF - 1)) begin
      n.div = 8'h00;
      n.sck = ~r.sck;
      if (!r.sck) begin
        n.cnt = r.cnt + 3'h1;
        case (r.st)
          H_OPC: begin
            if (r.cnt == QFR_OPC_LAST) begin
              n.cnt = 3'h0;
              if (r.cmd == QFR_CMD_RST) begin
                n.cont = 1'b0;
                n.st = H_END;
              end else begin
                n.st = H_ADDR;
              end
            end
          end
          H_ADDR: begin
            if (r.cnt == QFR_ADDR_LAST) begin
              n.cnt = 3'h0;
              n.st = H_MODE;
            end
          end
          H_MODE: begin
            if (r.cnt == QFR_MODE_LAST) begin
              n.cnt = 3'h0;
              n.cont = r.keep;
              n.oe = 1'b0;
              n.st = (qfr_dummy(r.cmd) == 3'h0) ? H_DATA : H_DUMMY;
            end
          end
          H_DUMMY: begin
            if (r.cnt == qfr_dummy(r.cmd) - 3'h1) begin
              n.cnt = 3'h0;
              n.st = H_DATA;
            end
          end
          H_DATA: begin
            n.rdata = {r.rdata[27:0], io_s};
            if (r.cnt == {r.len, 1'b1}) begin
              n.st = H_END;
            end
          end
          default: begin
            n.cnt = r.cnt;
          end
        endcase
      end else if (r.st == H_END) begin
        n.cs_n = 1'b1;
        // A mode reset frame still drives; let go with the select
        n.oe = 1'b0;
        n.st = H_GAP;
      end else begin
        {n.oe, n.out} = hnib(r.st, r.cnt, r.cmd, r.addr, r.keep);
      end
    end else begin
      n.div = r.div + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.cs_n <= 1'b1;
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_prdata = r.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = r.slverr;
  assign link.cs_n = r.cs_n;
  assign link.sck = r.sck;
  assign link.h_io_out = r.out;
  assign link.h_io_oe = r.oe;
endmodule : qfr_host_end

// ==== qfr_link_assertions.sv ====
// Timing checks on the quad link between the two ends
`timescale 1ns/1ps
module qfr_link_assertions (
  input logic i_clk_sys,
  input logic i_rst_b,
  input logic cs_n,
  input logic sck,
  input logic [3:0] h_io_out,
  input logic h_io_oe,
  input logic [3:0] d_io_out,
  input logic d_io_oe,
  input logic [3:0] io
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_high;
    sck [*8] ##1 !sck;
  endsequence
  sequence s_low;
    !sck [*8];
  endsequence

  AST_NO_FIGHT: assert property (!(h_io_oe && d_io_oe))
    else $error("both ends drive the io lines");
  AST_IDLE_SCK: assert property (cs_n |-> !sck)
    else $error("clock high while deselected");
  AST_HIGH_PHASE: assert property ($rose(sck) |-> s_high)
    else $error("clock high phase not eight cycles");
  AST_LOW_PHASE: assert property ($fell(sck) |-> s_low)
    else $error("clock low phase too short");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  AST_DEV_RELEASE: assert property ($rose(cs_n) |-> ##[0:8] !d_io_oe)
    else $error("device still drives after deselect");
  AST_DEV_TURN: assert property ($rose(d_io_oe) |-> !sck && !cs_n)
    else $error("device drive starts off a low clock");
  AST_DEV_NIBBLE: assert property (
    d_io_oe && $changed(d_io_out) |-> !sck)
    else $error("device nibble changes while clock high");
  AST_HOST_NIBBLE: assert property (
    !cs_n && h_io_oe && $changed(h_io_out) |-> !sck)
    else $error("host nibble changes while clock high");
  AST_DEV_LINES: assert property (d_io_oe |-> io == d_io_out)
    else $error("device nibble does not reach the io lines");
  AST_HOST_LET_GO: assert property ($fell(h_io_oe) && !cs_n |-> sck)
    else $error("host release not at a rising clock");
endmodule : qfr_link_assertions

// ==== tb.sv ====
// Self-checking bench: host and flash ends joined over the quad link
`timescale 1ns/1ps
module tb;
  import qfr_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, qe, wrap_wr;
  logic pready, pslverr, cont_mode, active, sck_q, cs_q, last_err, hc, dc;
  logic [7:0] paddr, mem_data, opc;
  logic [31:0] pwdata, prdata;
  logic [2:0] wrap_bits, wb;
  logic [23:0] mem_addr;
  logic [7:0] ops [4] = '{8'heb, 8'he7, 8'he3, 8'hff};
  int failures, total_checks, rises;

  qfr_link_if lk ();
  qfr_host_end qfr_host_end_i (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_ce(1'b1), .link(lk.host), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  qfr_dev_end qfr_dev_end_i (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_ce(1'b1), .link(lk.dev), .i_quad_io_enable(qe),
    .i_wrap_wr(wrap_wr), .i_wrap_bits(wrap_bits), .i_mem_data(mem_data),
    .o_mem_addr(mem_addr), .o_cont_mode(cont_mode), .o_active(active));
  qfr_link_assertions qfr_link_assertions_i (.i_clk_sys(clk),
    .i_rst_b(rst_b), .cs_n(lk.cs_n), .sck(lk.sck),
    .h_io_out(lk.h_io_out), .h_io_oe(lk.h_io_oe),
    .d_io_out(lk.d_io_out), .d_io_oe(lk.d_io_oe), .io(lk.io));

  // Memory content is a fixed function of the byte address
  assign mem_data = mem_addr[7:0] ^ 8'h3c;

  // Counts rising link clocks per frame and keeps the first eight io0 bits
  always @(posedge clk) begin
    sck_q <= lk.sck;
    cs_q <= lk.cs_n;
    if (cs_q && !lk.cs_n) begin
      rises <= 0;
    end else if (!sck_q && lk.sck && !lk.cs_n) begin
      rises <= rises + 1;
      if (rises < 8) opc <= {opc[6:0], lk.io[0]};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      failures++;
      close_out();
    end
  endtask : apb

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, QFR_REG_STAT, 32'h0, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 300) begin
      failures++;
      close_out();
    end
  endtask : wait_idle

  task automatic set_wrap(input logic [2:0] w);
    @(posedge clk);
    wrap_bits <= w;
    wrap_wr <= 1'b1;
    @(posedge clk);
    wrap_wr <= 1'b0;
    wb = w;
  endtask : set_wrap

  // One read frame; expectations follow from the bench's own state
  task automatic frame(input logic [1:0] cmd, input logic keep, input int n,
                       input logic [23:0] a);
    logic [31:0] q, e;
    logic [23:0] s, b, sz;
    logic ok;
    int k;
    // Address goes first since the control write starts the frame from it
    apb(1'b1, QFR_REG_ADDR, {8'h0, a}, q);
    s = cmd == 2'd1 ? a & 24'hfffffe : cmd == 2'd2 ? a & 24'hfffff0 : a;
    sz = 24'h8 << wb[2:1];
    // Without an opcode the flash answers only if it kept continuous mode
    ok = hc ? dc : qe;
    e = 32'h0;
    for (k = 0; k < n; k++) begin
      b = (s & ~(sz - 24'h1)) | ((s + 24'(k)) & (sz - 24'h1));
      if (wb[0]) b = s + 24'(k);
      e = {e[23:0], ok ? b[7:0] ^ 8'h3c : 8'hff};
    end
    apb(1'b1, QFR_REG_CTRL, {27'h0, 2'(n - 1), keep, cmd}, q);
    wait_idle();
    apb(1'b0, QFR_REG_RDATA, 32'h0, q);
    if (cmd != 2'd3) chk(q, e);
    chk(32'(rises), cmd == 2'd3 ? 8 : (hc ? 0 : 8) + 8 + 2 * n
        + (cmd == 2'd0 ? 4 : cmd == 2'd1 ? 2 : 0));
    if (!hc || cmd == 2'd3) chk({24'h0, opc}, {24'h0, ops[cmd]});
    hc = cmd != 2'd3 && keep;
    dc = cmd != 2'd3 && keep && ok;
    chk({30'h0, active, cont_mode}, {30'h0, 1'b0, dc});
    apb(1'b0, QFR_REG_STAT, 32'h0, q);
    chk({29'h0, q[2:0]}, {29'h0, 1'b1, hc, 1'b0});
  endtask : frame

  task automatic t_regs();
    logic [31:0] q;
    apb(1'b0, QFR_REG_STAT, 32'h0, q);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q);
    chk({q[30:0], last_err}, 32'h1);
  endtask : t_regs

  task automatic t_fast();
    frame(2'd0, 1'b0, 4, 24'h0000fe);
    frame(2'd0, 1'b1, 4, 24'h000123);
    frame(2'd0, 1'b0, 2, 24'h000456);
    frame(2'd0, 1'b0, 1, 24'h000010);
  endtask : t_fast

  task automatic t_word();
    frame(2'd1, 1'b1, 2, 24'h000201);
    frame(2'd1, 1'b0, 3, 24'h000305);
  endtask : t_word

  task automatic t_oct();
    frame(2'd2, 1'b1, 4, 24'h00034a);
    frame(2'd2, 1'b1, 1, 24'h000388);
    frame(2'd3, 1'b0, 1, 24'h000000);
    frame(2'd2, 1'b0, 2, 24'h000510);
  endtask : t_oct

  task automatic t_qe_off();
    qe <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      frame(2'(c), 1'b1, 2, 24'h000040);
    end
    qe <= 1'b1;
    // Host believes continuous while the flash does not; reset both
    frame(2'd3, 1'b0, 1, 24'h000000);
  endtask : t_qe_off

  task automatic t_wrap();
    logic [23:0] sz;
    for (int l = 0; l < 4; l++) begin
      set_wrap({2'(l), 1'b0});
      sz = 24'h8 << l;
      frame(2'd0, 1'b0, 4, 24'h000100 + sz - 24'h2);
      frame(2'd1, 1'b0, 4, 24'h000200 + sz - 24'h2);
    end
    set_wrap(3'h1);
    frame(2'd0, 1'b0, 4, 24'h00000e);
  endtask : t_wrap

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    qe = 1'b1;
    wrap_wr = 1'b0;
    wrap_bits = 3'h1;
    wb = 3'h1;
    hc = 1'b0;
    dc = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_fast();
    t_word();
    t_oct();
    t_qe_off();
    t_wrap();
    close_out();
  end
endmodule : tb
